// [lpbs_pkg.sv]
package lpbs_pkg;

	// ----------------------------------------------------------------
	// Device-level states
	// ----------------------------------------------------------------
	typedef enum logic [9:0] {
		DEV_POWER_ON  = 10'h001,
		DEV_RESETTING = 10'h002,
		DEV_NORMAL    = 10'h004,
		DEV_ACT_PD    = 10'h008,
		DEV_IDLE_PD   = 10'h010,
		DEV_RST_PD    = 10'h020,
		DEV_SELF_REF  = 10'h040,
		DEV_DEEP_PD   = 10'h080,
		DEV_MR_WRITE  = 10'h100,
		DEV_REF_ALL   = 10'h200
	} lpbs_dev_type;

	// ----------------------------------------------------------------
	// Per-bank states
	// ----------------------------------------------------------------
	typedef enum logic [7:0] {
		BK_IDLE      = 8'h01,
		BK_ACTIVATING = 8'h02,
		BK_ACTIVE    = 8'h04,
		BK_READING   = 8'h08,
		BK_WRITING   = 8'h10,
		BK_PRECHARGE = 8'h20,
		BK_REFRESH   = 8'h40,
		BK_MR_READ   = 8'h80
	} lpbs_bank_type;

	// ----------------------------------------------------------------
	// Decoded commands
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		CMD_NOP  = 4'h0,
		CMD_ACT  = 4'h1,
		CMD_RD   = 4'h2,
		CMD_WR   = 4'h3,
		CMD_PRE  = 4'h4,
		CMD_PREA = 4'h5,
		CMD_BST  = 4'h6,
		CMD_REFB = 4'h7,
		CMD_REFA = 4'h8,
		CMD_MRR  = 4'h9,
		CMD_MRW  = 4'hA,
		CMD_MRST = 4'hB,
		CMD_SREF = 4'hC,
		CMD_DPD  = 4'hD
	} lpbs_cmd_type;

	typedef struct packed {
		lpbs_cmd_type cmd;
		logic [2:0] bank;
		logic auto_pre;
		logic [3:0] burst_len;
	} lpbs_req_type;

	localparam int BANKS = 8;
	localparam int CLK_MHZ = 200;
	localparam int T_RP_NS = 18;
	localparam int T_RCD_NS = 18;
	localparam int T_RFCPB_NS = 90;
	localparam int T_RFCAB_NS = 210;
	localparam int T_MRR_CK = 2;
	localparam int T_MRW_CK = 5;
	localparam int T_INIT5_US = 10;
	localparam int RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
	localparam int RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
	localparam int RFCPB_CYC = (T_RFCPB_NS * CLK_MHZ + 999) / 1000;
	localparam int RFCAB_CYC = (T_RFCAB_NS * CLK_MHZ + 999) / 1000;
	localparam int INIT5_CYC = T_INIT5_US * CLK_MHZ;

endpackage

// [lpbs_state.sv]
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Transitions use prior state, CKE now and before, and CS# now.
// - Resetting power-down exit goes idle only if init wait expired.
// - Deep power-down exit returns to power-on.
// - Idle after tRP met; active after tRCD met and nothing pending.
// - Per-bank refresh only on idle bank; idle after tRFCpb.
// - No command but PREA to a bank inside precharge, activate windows; AP bursts take PRE and PREA.
// - Active MRR returns bank active; idle or reset MRR ends idle.
// - Precharge-all ends with all banks idle after tRP.
// - Precharge to an idle bank still takes full tRP.
// - Active bank takes read, write, MRR, precharge.
// - Reading or writing bank without AP takes new bursts, AP on or off.
// - Burst terminate stops latest burst, any bank, to active, unless it has AP.
// - MRW reset from power-on starts init; MRR allowed resetting.
module lpbs_state
	import lpbs_pkg::*;
#(
	parameter int INIT5_CYCLES = INIT5_CYC
) (
	// Clock, reset, enable
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic CLK_EN,
	// Command pins, already on MCLK
	input wire logic CKE,
	input wire logic CS_N,
	input wire lpbs_req_type REQ,
	// State view
	output lpbs_dev_type DEV_STATE,
	output logic [8*BANKS-1:0] BANK_STATE,
	output logic ALL_IDLE,
	output logic ILLEGAL
);

	initial begin
		if (INIT5_CYCLES < 1) $error("INIT5_CYCLES must be positive");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	lpbs_dev_type dev_r, dev_nxt;
	lpbs_bank_type bank_r [BANKS], bank_nxt [BANKS];
	logic [7:0] tmr_r [BANKS], tmr_nxt [BANKS];
	logic ap_r [BANKS], ap_nxt [BANKS];
	logic ret_act_r [BANKS], ret_act_nxt [BANKS];
	logic [7:0] dtmr_r, dtmr_nxt;
	logic [31:0] init_r, init_nxt;
	logic cke_prev_r, cke_prev_nxt;
	logic [2:0] last_bank_r, last_bank_nxt;
	logic ill_r, ill_nxt;

	function automatic logic [7:0] cyc8(input int c);
		return 8'(c);
	endfunction

	function automatic logic bank_busy(input lpbs_bank_type s);
		return s != BK_IDLE && s != BK_ACTIVE;
	endfunction

	logic all_idle_c;
	logic any_burst_c;
	always_comb begin
		all_idle_c = 1'b1;
		any_burst_c = 1'b0;
		for (int i = 0; i < BANKS; i++) begin
			if (bank_r[i] != BK_IDLE) all_idle_c = 1'b0;
			if (bank_r[i] inside {BK_READING, BK_WRITING}) begin
				any_burst_c = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		lpbs_req_type q;
		logic cmd_edge;
		logic any_active;
		q = REQ;
		cmd_edge = cke_prev_r && CKE && !CS_N;
		any_active = !all_idle_c;
		dev_nxt = dev_r;
		dtmr_nxt = dtmr_r;
		init_nxt = init_r;
		cke_prev_nxt = CKE;
		last_bank_nxt = last_bank_r;
		ill_nxt = 1'b0;
		for (int i = 0; i < BANKS; i++) begin
			bank_nxt[i] = bank_r[i];
			tmr_nxt[i] = tmr_r[i];
			ap_nxt[i] = ap_r[i];
			ret_act_nxt[i] = ret_act_r[i];
		end
		// Init wait runs in resetting and resetting power-down alike
		if (init_r != 32'h0) init_nxt = init_r - 32'h1;
		if (dtmr_r != 8'h0) dtmr_nxt = dtmr_r - 8'h1;
		// Bank timers and window completion
		for (int i = 0; i < BANKS; i++) begin
			if (tmr_r[i] != 8'h0) tmr_nxt[i] = tmr_r[i] - 8'h1;
			if (tmr_r[i] == 8'h1) begin
				case (bank_r[i])
					BK_ACTIVATING: bank_nxt[i] = BK_ACTIVE;
					BK_PRECHARGE: bank_nxt[i] = BK_IDLE;
					BK_REFRESH: bank_nxt[i] = BK_IDLE;
					BK_MR_READ: begin
						bank_nxt[i] = ret_act_r[i] ? BK_ACTIVE
							: BK_IDLE;
					end
					BK_READING, BK_WRITING: begin
						// Burst ran out; AP burst flows into precharge
						if (ap_r[i]) begin
							bank_nxt[i] = BK_PRECHARGE;
							tmr_nxt[i] = cyc8(RP_CYC);
						end else begin
							bank_nxt[i] = BK_ACTIVE;
						end
						ap_nxt[i] = 1'b0;
					end
					default: ;
				endcase
			end
		end
		// Device-level FSM; CKE table first, command table under CKE high
		case (dev_r)
			DEV_ACT_PD: if (CKE && CS_N) dev_nxt = DEV_NORMAL;
			DEV_IDLE_PD: if (CKE && CS_N) dev_nxt = DEV_NORMAL;
			DEV_SELF_REF: if (CKE && CS_N) dev_nxt = DEV_NORMAL;
			DEV_DEEP_PD: begin
				if (CKE && CS_N) dev_nxt = DEV_POWER_ON;
			end
			DEV_RST_PD: begin
				if (CKE && CS_N) begin
					dev_nxt = (init_r == 32'h0) ? DEV_NORMAL
						: DEV_RESETTING;
				end
			end
			DEV_MR_WRITE, DEV_REF_ALL: begin
				if (dtmr_r == 8'h1) dev_nxt = DEV_NORMAL;
				if (cmd_edge && q.cmd != CMD_NOP) ill_nxt = 1'b1;
			end
			DEV_POWER_ON: begin
				if (cmd_edge && q.cmd == CMD_MRST) begin
					dev_nxt = DEV_RESETTING;
					init_nxt = INIT5_CYCLES;
				end
			end
			DEV_RESETTING: begin
				if (cke_prev_r && !CKE && CS_N) begin
					dev_nxt = DEV_RST_PD;
				end else if (cmd_edge && q.cmd == CMD_MRR) begin
					// Resetting MR read; exits to normal idle
					bank_nxt[q.bank] = BK_MR_READ;
					tmr_nxt[q.bank] = cyc8(T_MRR_CK);
					ret_act_nxt[q.bank] = 1'b0;
					dev_nxt = DEV_NORMAL;
				end else if (init_r == 32'h0) begin
					dev_nxt = DEV_NORMAL;
				end
			end
			DEV_NORMAL: begin
				if (cke_prev_r && !CKE) begin
					if (CS_N) begin
						dev_nxt = any_active ? DEV_ACT_PD
							: DEV_IDLE_PD;
					end else if (all_idle_c && q.cmd == CMD_SREF) begin
						dev_nxt = DEV_SELF_REF;
					end else if (all_idle_c && q.cmd == CMD_DPD) begin
						dev_nxt = DEV_DEEP_PD;
					end else begin
						ill_nxt = 1'b1;
					end
				end else if (cmd_edge) begin
					case (q.cmd)
						CMD_ACT: begin
							if (bank_r[q.bank] == BK_IDLE) begin
								bank_nxt[q.bank] = BK_ACTIVATING;
								tmr_nxt[q.bank] = cyc8(RCD_CYC);
							end else ill_nxt = 1'b1;
						end
						CMD_RD, CMD_WR: begin
							if ((bank_r[q.bank] == BK_ACTIVE
								|| bank_r[q.bank] == BK_READING
								|| bank_r[q.bank] == BK_WRITING)
								&& !ap_r[q.bank]) begin
								bank_nxt[q.bank] = (q.cmd == CMD_RD)
									? BK_READING : BK_WRITING;
								tmr_nxt[q.bank] = 8'(q.burst_len);
								ap_nxt[q.bank] = q.auto_pre;
								last_bank_nxt = q.bank;
							end else ill_nxt = 1'b1;
						end
						CMD_BST: begin
							// Latest burst stops wherever it is
							if ((bank_r[last_bank_r] == BK_READING
								|| bank_r[last_bank_r] == BK_WRITING)
								&& !ap_r[last_bank_r]) begin
								bank_nxt[last_bank_r] = BK_ACTIVE;
								tmr_nxt[last_bank_r] = 8'h0;
							end else ill_nxt = 1'b1;
						end
						CMD_PRE: begin
							// Idle bank still pays full tRP
							if (!bank_busy(bank_r[q.bank])
								|| bank_r[q.bank] == BK_READING
								|| bank_r[q.bank] == BK_WRITING) begin
								bank_nxt[q.bank] = BK_PRECHARGE;
								tmr_nxt[q.bank] = cyc8(RP_CYC);
								ap_nxt[q.bank] = 1'b0;
							end else ill_nxt = 1'b1;
						end
						CMD_PREA: begin
							for (int i = 0; i < BANKS; i++) begin
								bank_nxt[i] = BK_PRECHARGE;
								tmr_nxt[i] = cyc8(RP_CYC);
								ap_nxt[i] = 1'b0;
							end
						end
						CMD_REFB: begin
							// A burst anywhere still owns the data path
							if (bank_r[q.bank] == BK_IDLE
								&& !any_burst_c) begin
								bank_nxt[q.bank] = BK_REFRESH;
								tmr_nxt[q.bank] = cyc8(RFCPB_CYC);
							end else ill_nxt = 1'b1;
						end
						CMD_REFA, CMD_MRW: begin
							if (all_idle_c) begin
								dev_nxt = (q.cmd == CMD_REFA)
									? DEV_REF_ALL : DEV_MR_WRITE;
								dtmr_nxt = (q.cmd == CMD_REFA)
									? cyc8(RFCAB_CYC) : cyc8(T_MRW_CK);
							end else ill_nxt = 1'b1;
						end
						CMD_MRST: begin
							if (all_idle_c) begin
								dev_nxt = DEV_RESETTING;
								init_nxt = INIT5_CYCLES;
							end else ill_nxt = 1'b1;
						end
						CMD_MRR: begin
							if (bank_r[q.bank] == BK_ACTIVE
								|| bank_r[q.bank] == BK_IDLE) begin
								ret_act_nxt[q.bank] =
									bank_r[q.bank] == BK_ACTIVE;
								bank_nxt[q.bank] = BK_MR_READ;
								tmr_nxt[q.bank] = cyc8(T_MRR_CK);
							end else ill_nxt = 1'b1;
						end
						default: ill_nxt = 1'b1;
					endcase
				end
			end
			default: dev_nxt = DEV_POWER_ON;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (SRST) begin
			dev_r <= DEV_POWER_ON;
			dtmr_r <= 8'h0;
			init_r <= 32'h0;
			cke_prev_r <= 1'b0;
			last_bank_r <= 3'h0;
			ill_r <= 1'b0;
			for (int i = 0; i < BANKS; i++) begin
				bank_r[i] <= BK_IDLE;
				tmr_r[i] <= 8'h0;
				ap_r[i] <= 1'b0;
				ret_act_r[i] <= 1'b0;
			end
		end else if (CLK_EN) begin
			dev_r <= dev_nxt;
			dtmr_r <= dtmr_nxt;
			init_r <= init_nxt;
			cke_prev_r <= cke_prev_nxt;
			last_bank_r <= last_bank_nxt;
			ill_r <= ill_nxt;
			for (int i = 0; i < BANKS; i++) begin
				bank_r[i] <= bank_nxt[i];
				tmr_r[i] <= tmr_nxt[i];
				ap_r[i] <= ap_nxt[i];
				ret_act_r[i] <= ret_act_nxt[i];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < BANKS; i++) begin
			BANK_STATE[8*i +: 8] = bank_r[i];
		end
	end

	assign DEV_STATE = dev_r;
	assign ALL_IDLE = all_idle_c;
	assign ILLEGAL = ill_r;

endmodule
`default_nettype wire

// [lpbs_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module lpbs_chk
	import lpbs_pkg::*;
#(
	parameter int INIT5_CYCLES = INIT5_CYC
) (
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic CLK_EN,
	input wire logic CKE,
	input wire logic CS_N,
	input wire lpbs_req_type REQ,
	input wire lpbs_dev_type DEV_STATE,
	input wire logic [8*BANKS-1:0] BANK_STATE,
	input wire logic ALL_IDLE,
	input wire logic ILLEGAL
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);
	wire [7:0] b0 = BANK_STATE[7:0];
	wire [7:0] b2 = BANK_STATE[23:16];
	wire take = CLK_EN && CKE && !CS_N;
	logic burst;
	always_comb begin
		burst = 1'b0;
		for (int i = 0; i < BANKS; i++) begin
			if (BANK_STATE[8*i +: 8] inside {BK_READING, BK_WRITING}) begin
				burst = 1'b1;
			end
		end
	end
	int rcnt_r;
	// Counts time in resetting; margin of one covers the entry edge
	always_ff @(posedge MCLK) begin
		if (SRST || !(DEV_STATE inside {DEV_RESETTING, DEV_RST_PD})) begin
			rcnt_r <= 0;
		end else begin
			rcnt_r <= rcnt_r + 1;
		end
	end
	property p_rcd;
		$rose(b0 == BK_ACTIVATING) |-> (b0 == BK_ACTIVATING) [*4] ##1
			b0 == BK_ACTIVE;
	endproperty
	a_rcd: assert property (p_rcd) else $error("activate time wrong");
	property p_pre;
		$rose(b0 == BK_PRECHARGE) |-> (b0 == BK_PRECHARGE) [*4] ##1
			b0 == BK_IDLE;
	endproperty
	a_pre: assert property (p_pre) else $error("precharge time wrong");
	property p_refb;
		take && $past(CKE) && REQ.cmd == CMD_REFB && REQ.bank == 3'h2 &&
			b2 == BK_IDLE && !burst && DEV_STATE == DEV_NORMAL |=>
			b2 == BK_REFRESH ##17 b2 == BK_REFRESH ##1 b2 == BK_IDLE;
	endproperty
	a_refb: assert property (p_refb) else $error("bank refresh wrong");
	property p_ill;
		take && $past(CKE) && REQ.bank == 3'h0 && b0 == BK_ACTIVATING &&
			REQ.cmd inside {CMD_ACT, CMD_RD, CMD_WR} |=> ILLEGAL;
	endproperty
	a_ill: assert property (p_ill) else $error("busy bank accepted");
	property p_pde;
		$past(CKE) && !CKE && CS_N && CLK_EN && DEV_STATE == DEV_NORMAL |=>
			DEV_STATE == ($past(ALL_IDLE) ? DEV_IDLE_PD : DEV_ACT_PD);
	endproperty
	a_pde: assert property (p_pde) else $error("power-down entry");
	property p_pdx;
		DEV_STATE inside {DEV_ACT_PD, DEV_IDLE_PD, DEV_SELF_REF} &&
			!$past(CKE) && CKE && CS_N && CLK_EN |=> DEV_STATE == DEV_NORMAL;
	endproperty
	a_pdx: assert property (p_pdx) else $error("power-down exit");
	property p_mrst;
		take && $past(CKE) && REQ.cmd == CMD_MRST &&
			DEV_STATE == DEV_POWER_ON |=> DEV_STATE == DEV_RESETTING;
	endproperty
	a_mrst: assert property (p_mrst) else $error("reset not started");
	property p_init;
		DEV_STATE == DEV_RESETTING |-> rcnt_r <= INIT5_CYCLES + 1;
	endproperty
	a_init: assert property (p_init) else $error("init wait overrun");
	c_sref: cover property (DEV_STATE == DEV_SELF_REF);
	c_dpd: cover property (DEV_STATE == DEV_DEEP_PD);
	c_ill: cover property (ILLEGAL);
endmodule
bind lpbs_state lpbs_chk #(.INIT5_CYCLES(INIT5_CYCLES)) chk (.MCLK(MCLK),
	.SRST(SRST), .CLK_EN(CLK_EN), .CKE(CKE), .CS_N(CS_N), .REQ(REQ),
	.DEV_STATE(DEV_STATE), .BANK_STATE(BANK_STATE), .ALL_IDLE(ALL_IDLE),
	.ILLEGAL(ILLEGAL));
`default_nettype wire

// [lpbs_ctl.sv]
`timescale 1ns/10ps
`default_nettype none
module lpbs_ctl
	import lpbs_pkg::*;
#(
	parameter int XP_CYC = 2
) (
	// Clock
	input wire logic MCLK,
	// Command pins
	output logic CKE,
	output logic CS_N,
	output lpbs_req_type REQ
);
	initial begin
		CKE = 1'b1;
		CS_N = 1'b1;
		REQ = '0;
	end
	// Released bus toggles so a stale command never reads as new
	task automatic idle(int n);
		repeat (n) begin
			@(posedge MCLK) #1;
			CS_N = 1'b1;
			REQ = ~REQ;
		end
	endtask
	task automatic put(logic k, logic s, lpbs_cmd_type c, logic [2:0] b,
		logic a, logic [3:0] l);
		@(posedge MCLK) #1;
		CKE = k;
		CS_N = s;
		REQ = '{c, b, a, l};
		idle(1);
	endtask
	// Exit with CS_N high, then NOP only until the exit time has run
	task automatic wake();
		put(1'b1, 1'b1, CMD_NOP, 3'h0, 1'b0, 4'h0);
		idle(XP_CYC);
	endtask
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import lpbs_pkg::*;
	logic MCLK = 1'b0;
	logic SRST = 1'b1;
	logic CLK_EN = 1'b1;
	wire CKE;
	wire CS_N;
	wire lpbs_req_type REQ;
	wire lpbs_dev_type DEV_STATE;
	wire [8*BANKS-1:0] BANK_STATE;
	wire ALL_IDLE;
	wire ILLEGAL;
	int errors = 0;
	int comparisons = 0;
	lpbs_ctl ctl (.MCLK(MCLK), .CKE(CKE), .CS_N(CS_N), .REQ(REQ));
	lpbs_state #(.INIT5_CYCLES(8)) uut (.MCLK(MCLK), .SRST(SRST),
		.CLK_EN(CLK_EN), .CKE(CKE), .CS_N(CS_N), .REQ(REQ),
		.DEV_STATE(DEV_STATE), .BANK_STATE(BANK_STATE),
		.ALL_IDLE(ALL_IDLE), .ILLEGAL(ILLEGAL));
	function automatic logic [7:0] bk(int i);
		return BANK_STATE[8*i+:8];
	endfunction
	task automatic cmp(string n, logic [9:0] e, logic [9:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cmd(lpbs_cmd_type c, int b, logic a = 0, int l = 1);
		ctl.put(1'b1, 1'b0, c, 3'(b), a, 4'(l));
	endtask
	task automatic pd(logic s, lpbs_cmd_type c);
		ctl.put(1'b0, s, c, 3'h0, 1'b0, 4'h0);
	endtask
	task automatic test_done();
		if (errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic t_init();
		cmp("dev", DEV_POWER_ON, DEV_STATE);
		cmd(CMD_MRST, 0);
		cmp("dev", DEV_RESETTING, DEV_STATE);
		pd(1'b1, CMD_NOP);
		cmp("dev", DEV_RST_PD, DEV_STATE);
		ctl.wake();
		cmp("dev", DEV_RESETTING, DEV_STATE);
		cmd(CMD_MRR, 0);
		cmp("illegal", 1'b0, ILLEGAL);
		ctl.idle(3);
		cmp("dev", DEV_NORMAL, DEV_STATE);
		cmp("all_idle", 1'b1, ALL_IDLE);
		SRST = 1'b1;
		ctl.idle(2);
		SRST = 1'b0;
		ctl.idle(2);
		cmd(CMD_MRST, 0);
		pd(1'b1, CMD_NOP);
		ctl.idle(12);
		cmp("dev", DEV_RST_PD, DEV_STATE);
		ctl.wake();
		cmp("dev", DEV_NORMAL, DEV_STATE);
	endtask
	task automatic t_bank();
		cmd(CMD_ACT, 0);
		cmp("bank0", BK_ACTIVATING, bk(0));
		cmd(CMD_ACT, 0);
		cmp("illegal", 1'b1, ILLEGAL);
		cmd(CMD_ACT, 1);
		ctl.idle(4);
		cmd(CMD_RD, 0, 1'b0, 8);
		cmp("bank0", BK_READING, bk(0));
		cmd(CMD_RD, 1, 1'b0, 8);
		cmd(CMD_BST, 0);
		cmp("bank1", BK_ACTIVE, bk(1));
		cmd(CMD_RD, 1, 1'b0, 8);
		cmd(CMD_RD, 1, 1'b1, 2);
		cmp("bank1", BK_READING, bk(1));
		ctl.idle(2);
		cmp("bank1", BK_PRECHARGE, bk(1));
		ctl.idle(4);
		cmp("bank1", BK_IDLE, bk(1));
		cmp("bank0", BK_ACTIVE, bk(0));
		cmd(CMD_MRR, 0);
		ctl.idle(2);
		cmp("bank0", BK_ACTIVE, bk(0));
		cmd(CMD_REFB, 0);
		cmp("illegal", 1'b1, ILLEGAL);
		cmd(CMD_REFB, 2);
		cmp("bank2", BK_REFRESH, bk(2));
		ctl.idle(18);
		cmp("bank2", BK_IDLE, bk(2));
		cmd(CMD_PRE, 3);
		ctl.idle(3);
		cmp("bank3", BK_PRECHARGE, bk(3));
		cmd(CMD_WR, 0, 1'b0, 2);
		cmp("bank0", BK_WRITING, bk(0));
		ctl.idle(2);
		cmd(CMD_RD, 0, 1'b0, 8);
		cmd(CMD_REFB, 2);
		cmp("illegal", 1'b1, ILLEGAL);
		cmd(CMD_BST, 0);
		cmp("bank0", BK_ACTIVE, bk(0));
		cmd(CMD_WR, 0, 1'b0, 1);
		cmp("bank0", BK_WRITING, bk(0));
	endtask
	task automatic t_power();
		pd(1'b1, CMD_NOP);
		cmp("dev", DEV_ACT_PD, DEV_STATE);
		ctl.wake();
		cmp("dev", DEV_NORMAL, DEV_STATE);
		cmd(CMD_PREA, 0);
		ctl.idle(4);
		cmp("all_idle", 1'b1, ALL_IDLE);
		pd(1'b1, CMD_NOP);
		cmp("dev", DEV_IDLE_PD, DEV_STATE);
		ctl.wake();
		pd(1'b0, CMD_SREF);
		ctl.idle(3);
		cmp("dev", DEV_SELF_REF, DEV_STATE);
		ctl.wake();
		cmp("dev", DEV_NORMAL, DEV_STATE);
		cmd(CMD_REFA, 0);
		cmd(CMD_ACT, 0);
		cmp("illegal", 1'b1, ILLEGAL);
		// Frozen clock enable must hold the pulse and stretch the window
		CLK_EN = 1'b0;
		ctl.idle(10);
		cmp("illegal", 1'b1, ILLEGAL);
		CLK_EN = 1'b1;
		ctl.idle(39);
		cmp("dev", DEV_REF_ALL, DEV_STATE);
		ctl.idle(1);
		cmp("dev", DEV_NORMAL, DEV_STATE);
		cmd(CMD_MRW, 0);
		cmp("dev", DEV_MR_WRITE, DEV_STATE);
		ctl.idle(5);
		pd(1'b0, CMD_DPD);
		cmp("dev", DEV_DEEP_PD, DEV_STATE);
		ctl.wake();
		cmp("dev", DEV_POWER_ON, DEV_STATE);
	endtask
	initial begin
		forever #2.5 MCLK = ~MCLK;
	end
	initial begin
		repeat (3000) @(posedge MCLK);
		errors++;
		test_done();
	end
	initial begin
		ctl.idle(2);
		SRST = 1'b0;
		ctl.idle(2);
		t_init();
		t_bank();
		t_power();
		test_done();
	end
endmodule
`default_nettype wire
